// ===== ddc_test_format_ctl.sv
// decode of the i/o format tail and the test control word
`include "ddc_regs.svh"

// Function
// - two-bit field: 00 tristates q pin, 01 drives, 1x drives in slot
// - input format bit: zero offset binary, one two's complement
// - 13-bit rate counter preload; valid only from 2 through 1701
// - test word address 111; bit 36 updates this word or all words
// - input force bit replaces every sample with 8000 hex
// - accumulator code 00: normal, cleared each fir output cycle
// - accumulator code 01: accumulator disabled, nothing accumulates
// - code 10: accumulator never cleared, checksum; code 11 reserved
// - rollover bit: q pin pulses on phase generator rollover
// - force bit holds clock, strobe, i, q pins at bits 8..5
// - generator bypass sets sine and cosine to 0.fffff
// - scaling bypass uses scale factor of exactly one
// - wait-for-fill suppresses output after reset until ram filled
// - bit 0 set disables overflow protection
// - test features act only while the test enable bit is one
// - address and update bits route only and are not stored
module ddc_test_format_ctl
	import ddc_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int TRIG_W = 20,
	parameter int SCALE_W = 17,
	parameter logic [SCALE_W-1:0] SCALE_ONE = 17'h10000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	input wire logic test_enable,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic [TRIG_W-1:0] sine_in,
	input wire logic [TRIG_W-1:0] cosine_in,
	input wire logic [SCALE_W-1:0] scale_in,
	input wire logic fir_cycle_start,
	input wire logic phase_rollover,
	input wire logic ram_filled,
	input wire logic in_time_slot,
	input wire logic q_data,
	input wire logic i_data,
	input wire logic clock_data,
	input wire logic strobe_data,
	output logic [SAMPLE_W-1:0] sample_out,
	output logic sample_twos_comp,
	output logic [TRIG_W-1:0] sine_out,
	output logic [TRIG_W-1:0] cosine_out,
	output logic [SCALE_W-1:0] scale_out,
	output logic acc_enable,
	output logic acc_clear,
	output logic ovf_protect_en,
	output logic [12:0] rate_preload,
	output logic preload_valid,
	output logic update_all,
	output logic output_hold,
	output logic q_out,
	output logic q_oe_n,
	output logic i_out,
	output logic serial_out_clock,
	output logic output_word_strobe
);
	ddc_cmd_if cmd ();
	ddc_word_type io_format_shadow_reg;
	ddc_word_type io_format_reg;
	ddc_word_type test_shadow_reg;
	ddc_word_type test_reg;
	logic fill_seen_reg;
	logic [SAMPLE_W-1:0] sample_reg;
	logic twos_reg;
	logic [TRIG_W-1:0] sine_reg;
	logic [TRIG_W-1:0] cosine_reg;
	logic [SCALE_W-1:0] scale_reg;
	logic acc_en_reg;
	logic acc_clr_reg;
	logic ovf_reg;
	logic [12:0] preload_reg;
	logic preload_ok_reg;
	logic upd_all_reg;
	logic hold_reg;
	logic q_reg;
	logic q_oe_n_reg;
	logic i_reg;
	logic sclk_reg;
	logic stb_reg;

	ddc_cmd_rx u_rx (
		.clk(clk),
		.rst_n(rst_n),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_load(ser_load),
		.cmd(cmd)
	);

	// routing of a received word; address and update bits are dropped
	wire logic [2:0] cmd_addr = cmd.word[`DDC_ADDR_MSB:`DDC_ADDR_LSB];
	wire logic cmd_upd = cmd.word[`DDC_UPDATE_BIT];
	wire ddc_word_type cmd_body = cmd.word[`DDC_STORE_MSB:0];
	wire logic hit_io = cmd.word_valid && (cmd_addr == `DDC_IO_FORMAT_ADDR);
	wire logic hit_test = cmd.word_valid && (cmd_addr == `DDC_TEST_ADDR);
	wire logic upd_now = cmd.word_valid && cmd_upd;

	// shadow copies take every addressed word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_format_shadow_reg <= `DDC_IO_FORMAT_RESET;
			test_shadow_reg <= `DDC_TEST_RESET;
		end else begin
			if (hit_io) begin
				io_format_shadow_reg <= cmd_body;
			end
			if (hit_test) begin
				test_shadow_reg <= cmd_body;
			end
		end
	end

	// active copies: this word alone, or all words when update is set
	wire ddc_word_type io_next = hit_io ? cmd_body : io_format_shadow_reg;
	wire ddc_word_type test_next = hit_test ? cmd_body : test_shadow_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_format_reg <= `DDC_IO_FORMAT_RESET;
			test_reg <= `DDC_TEST_RESET;
			upd_all_reg <= 1'b0;
		end else begin
			if (hit_io || upd_now) begin
				io_format_reg <= io_next;
			end
			if (hit_test || upd_now) begin
				test_reg <= test_next;
			end
			upd_all_reg <= upd_now;
		end
	end

	// test features gated by the enable bit from the phase word
	wire logic t_in = test_enable && test_reg[`DDC_FORCE_IN_BIT];
	wire logic t_roll = test_enable && test_reg[`DDC_ROLL_BIT];
	wire logic t_force = test_enable && test_reg[`DDC_FORCE_OUT_BIT];
	wire logic t_gen = test_enable && test_reg[`DDC_GEN_BYP_BIT];
	wire logic t_scale = test_enable && test_reg[`DDC_SCALE_BYP_BIT];
	wire logic t_wait = test_enable && test_reg[`DDC_WAIT_FILL_BIT];
	wire logic t_ovf = test_enable && test_reg[`DDC_OVF_DIS_BIT];
	wire logic [1:0] acc_code = test_enable ?
		test_reg[`DDC_ACC_MSB:`DDC_ACC_LSB] : 2'h0;
	ddc_acc_type acc_mode;
	assign acc_mode = ddc_acc_decode(acc_code);

	// accumulator controls per mode
	wire logic acc_en_next = (acc_mode != DDC_ACC_OFF);
	wire logic acc_clr_next = fir_cycle_start &&
		(acc_mode == DDC_ACC_NORMAL);

	// format fields of the i/o word
	wire logic [1:0] q_ts = io_format_reg[`DDC_Q_TS_MSB:`DDC_Q_TS_LSB];
	wire logic [12:0] pre = io_format_reg[`DDC_PRE_MSB:`DDC_PRE_LSB];
	wire logic pre_ok = (pre >= `DDC_PRE_MIN) && (pre <= `DDC_PRE_MAX);

	// q pin drive: 01 always, 1x only inside the time slot
	wire logic q_drive = q_ts[1] ? in_time_slot : q_ts[0];

	// pin data: forced levels win over rollover strobe over data
	wire logic q_next = t_force ? test_reg[`DDC_F_Q_BIT] :
		(t_roll ? phase_rollover : q_data);
	wire logic i_next = t_force ? test_reg[`DDC_F_I_BIT] : i_data;
	wire logic clk_next = t_force ? test_reg[`DDC_F_CLK_BIT] : clock_data;
	wire logic stb_next = t_force ? test_reg[`DDC_F_STB_BIT] : strobe_data;

	// datapath substitutions
	wire logic [SAMPLE_W-1:0] smp_next = t_in ?
		SAMPLE_W'(`DDC_FORCED_SAMPLE) : sample_in;
	wire logic [TRIG_W-1:0] sin_next = t_gen ?
		TRIG_W'(`DDC_NEAR_ONE) : sine_in;
	wire logic [TRIG_W-1:0] cos_next = t_gen ?
		TRIG_W'(`DDC_NEAR_ONE) : cosine_in;
	wire logic [SCALE_W-1:0] scl_next = t_scale ? SCALE_ONE : scale_in;

	// ram fill seen since reset; set only, cleared by reset alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fill_seen_reg <= 1'b0;
		end else if (ram_filled) begin
			fill_seen_reg <= 1'b1;
		end
	end

	// registered datapath and control outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_reg <= '0;
			twos_reg <= 1'b0;
			sine_reg <= '0;
			cosine_reg <= '0;
			scale_reg <= '0;
			acc_en_reg <= 1'b1;
			acc_clr_reg <= 1'b0;
			ovf_reg <= 1'b1;
			preload_reg <= 13'h0000;
			preload_ok_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			sample_reg <= smp_next;
			twos_reg <= io_format_reg[`DDC_IN_FMT_BIT];
			sine_reg <= sin_next;
			cosine_reg <= cos_next;
			scale_reg <= scl_next;
			acc_en_reg <= acc_en_next;
			acc_clr_reg <= acc_clr_next;
			ovf_reg <= ~t_ovf;
			preload_reg <= pre;
			preload_ok_reg <= pre_ok;
			hold_reg <= t_wait && !fill_seen_reg && !ram_filled;
		end
	end

	// registered pin outputs; enable is low while the pin is driven
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= 1'b0;
			q_oe_n_reg <= 1'b1;
			i_reg <= 1'b0;
			sclk_reg <= 1'b0;
			stb_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
			q_oe_n_reg <= ~q_drive;
			i_reg <= i_next;
			sclk_reg <= clk_next;
			stb_reg <= stb_next;
		end
	end

	assign sample_out = sample_reg;
	assign sample_twos_comp = twos_reg;
	assign sine_out = sine_reg;
	assign cosine_out = cosine_reg;
	assign scale_out = scale_reg;
	assign acc_enable = acc_en_reg;
	assign acc_clear = acc_clr_reg;
	assign ovf_protect_en = ovf_reg;
	assign rate_preload = preload_reg;
	assign preload_valid = preload_ok_reg;
	assign update_all = upd_all_reg;
	assign output_hold = hold_reg;
	assign q_out = q_reg;
	assign q_oe_n = q_oe_n_reg;
	assign i_out = i_reg;
	assign serial_out_clock = sclk_reg;
	assign output_word_strobe = stb_reg;
endmodule : ddc_test_format_ctl

// ===== ddc_regs.svh
// register offsets, field positions, reset values and constants
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
`define DDC_WORD_W 40
`define DDC_ADDR_MSB 39
`define DDC_ADDR_LSB 37
`define DDC_UPDATE_BIT 36
`define DDC_STORE_MSB 35
`define DDC_IO_FORMAT_ADDR 3'h6
`define DDC_TEST_ADDR 3'h7
`define DDC_IO_FORMAT_RESET 36'h000000000
`define DDC_TEST_RESET 36'h000000000
`define DDC_Q_TS_MSB 15
`define DDC_Q_TS_LSB 14
`define DDC_IN_FMT_BIT 13
`define DDC_PRE_MSB 12
`define DDC_PRE_LSB 0
`define DDC_PRE_MIN 13'h0002
`define DDC_PRE_MAX 13'h06a5
`define DDC_FORCE_IN_BIT 13
`define DDC_ACC_MSB 12
`define DDC_ACC_LSB 11
`define DDC_ROLL_BIT 10
`define DDC_FORCE_OUT_BIT 9
`define DDC_F_CLK_BIT 8
`define DDC_F_STB_BIT 7
`define DDC_F_I_BIT 6
`define DDC_F_Q_BIT 5
`define DDC_GEN_BYP_BIT 4
`define DDC_SCALE_BYP_BIT 3
`define DDC_WAIT_FILL_BIT 1
`define DDC_OVF_DIS_BIT 0
`define DDC_FORCED_SAMPLE 16'h8000
`define DDC_NEAR_ONE 20'hfffff
`endif

// ===== ddc_pkg.sv
// types shared by the control-word decode modules
package ddc_pkg;
	typedef logic [35:0] ddc_word_type;
	typedef logic [39:0] ddc_cmd_type;
	typedef enum {DDC_ACC_NORMAL, DDC_ACC_OFF, DDC_ACC_CONT} ddc_acc_type;

	// accumulator control code to mode; code 11 behaves as normal
	function automatic ddc_acc_type ddc_acc_decode(input logic [1:0] code);
		unique case (code)
			2'h1: ddc_acc_decode = DDC_ACC_OFF;
			2'h2: ddc_acc_decode = DDC_ACC_CONT;
			default: ddc_acc_decode = DDC_ACC_NORMAL;
		endcase
	endfunction : ddc_acc_decode
endpackage : ddc_pkg

// ===== ddc_cmd_if.sv
// carrier for complete command words from the serial receiver
interface ddc_cmd_if;
	import ddc_pkg::*;
	logic word_valid;
	ddc_cmd_type word;
	modport src (output word_valid, output word);
	modport dst (input word_valid, input word);
endinterface : ddc_cmd_if

// ===== ddc_cmd_rx.sv
// serial command receiver: synchronises pins and assembles 40-bit words
module ddc_cmd_rx
	import ddc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	ddc_cmd_if.src cmd
);
	logic [1:0] clk_sync_reg;
	logic [1:0] data_sync_reg;
	logic [1:0] load_sync_reg;
	logic clk_prev_reg;
	logic load_prev_reg;
	ddc_cmd_type shift_reg;
	logic valid_reg;
	ddc_cmd_type word_reg;
	wire logic clk_rise;
	wire logic load_rise;

	// two-flop synchronisers for the three command pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sync_reg <= 2'h0;
			data_sync_reg <= 2'h0;
			load_sync_reg <= 2'h0;
			clk_prev_reg <= 1'b0;
			load_prev_reg <= 1'b0;
		end else begin
			clk_sync_reg <= {clk_sync_reg[0], ser_clk};
			data_sync_reg <= {data_sync_reg[0], ser_data};
			load_sync_reg <= {load_sync_reg[0], ser_load};
			clk_prev_reg <= clk_sync_reg[1];
			load_prev_reg <= load_sync_reg[1];
		end
	end

	assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
	assign load_rise = load_sync_reg[1] & ~load_prev_reg;

	// bits enter msb first; load edge hands the word on for one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 40'h0000000000;
			valid_reg <= 1'b0;
			word_reg <= 40'h0000000000;
		end else begin
			if (clk_rise) begin
				shift_reg <= {shift_reg[38:0], data_sync_reg[1]};
			end
			valid_reg <= load_rise;
			if (load_rise) begin
				word_reg <= shift_reg;
			end
		end
	end

	assign cmd.word_valid = valid_reg;
	assign cmd.word = word_reg;
endmodule : ddc_cmd_rx

// ===== ddc_host_model.sv
// host-side model of the serial command port
module ddc_host_model (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_load
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: clock and load low between words
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_load = 1'b0;
	end
	// rate counter preload from decimation factor and slot length
	function automatic logic [12:0] preload(int decim, int slot_len);
		return 13'((decim * 4) / slot_len - 1);
	endfunction : preload
	// every pin level stands four device clocks
	task automatic hold4();
		repeat (4) @(posedge clk);
		#1;
	endtask : hold4
	// msb first, then a load pulse; data line left inverted after it
	task automatic send(input logic [39:0] w);
		logic [39:0] v;
		v = w;
		if (v[39:37] == 3'h7)
			v[2] = 1'b0;
		for (int b = 39; b >= 0; b--) begin
			ser_clk = 1'b0;
			ser_data = v[b];
			hold4();
			ser_clk = 1'b1;
			hold4();
		end
		ser_clk = 1'b0;
		ser_load = 1'b1;
		hold4();
		ser_load = 1'b0;
		ser_data = ~ser_data;
		hold4();
	endtask : send
endmodule : ddc_host_model

// ===== ddc_test_format_ctl_chk.sv
// assertions on the ports of the control-word decode block
`include "ddc_regs.svh"
module ddc_test_format_ctl_chk #(
	parameter int SAMPLE_W = 16,
	parameter int TRIG_W = 20,
	parameter int SCALE_W = 17,
	parameter logic [SCALE_W-1:0] SCALE_ONE = 17'h10000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic test_enable,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic [TRIG_W-1:0] sine_in,
	input wire logic [SCALE_W-1:0] scale_in,
	input wire logic fir_cycle_start,
	input wire logic q_data,
	input wire logic [SAMPLE_W-1:0] sample_out,
	input wire logic [TRIG_W-1:0] sine_out,
	input wire logic [SCALE_W-1:0] scale_out,
	input wire logic acc_enable,
	input wire logic acc_clear,
	input wire logic ovf_protect_en,
	input wire logic [12:0] rate_preload,
	input wire logic preload_valid,
	input wire logic update_all,
	input wire logic output_hold,
	input wire logic q_out,
	input wire logic q_oe_n
);
	logic [2:0] up_cnt;
	logic up;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// settle counter so history from reset is never judged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			up_cnt <= 3'h0;
		else if (!up)
			up_cnt <= up_cnt + 3'h1;
	end
	assign up = up_cnt == 3'h7;
	sample_pass_a: assert property (up && !$past(test_enable)
		|-> sample_out == $past(sample_in)) else $error("sample altered");
	trig_pass_a: assert property (up && !$past(test_enable)
		|-> sine_out == $past(sine_in)) else $error("sine altered");
	scale_sel_a: assert property (up |-> scale_out == $past(scale_in)
		|| scale_out == SCALE_ONE) else $error("scale wrong");
	ovf_on_a: assert property (up && !$past(test_enable)
		|-> ovf_protect_en) else $error("overflow guard off");
	clear_cause_a: assert property (acc_clear
		|-> $past(fir_cycle_start) && acc_enable) else $error("bad clear");
	clear_norm_a: assert property (up && !$past(test_enable)
		&& $past(fir_cycle_start) |-> acc_clear) else $error("no clear");
	hold_off_a: assert property (up && !$past(test_enable)
		|-> !output_hold) else $error("hold without test");
	preload_rng_a: assert property (preload_valid ==
		(rate_preload >= `DDC_PRE_MIN && rate_preload <= `DDC_PRE_MAX))
		else $error("preload range");
	upd_pulse_a: assert property (update_all |=> !update_all)
		else $error("update not a pulse");
	q_pass_a: assert property (up && !$past(test_enable)
		|-> q_out == $past(q_data)) else $error("q data altered");
	// main scenarios seen
	cover property (acc_clear);
	cover property (update_all);
	cover property (output_hold);
	cover property (!q_oe_n);
endmodule : ddc_test_format_ctl_chk
bind ddc_test_format_ctl ddc_test_format_ctl_chk #(.SAMPLE_W(SAMPLE_W),
	.TRIG_W(TRIG_W), .SCALE_W(SCALE_W), .SCALE_ONE(SCALE_ONE)) u_chk (.*);

// ===== ddc_test_format_ctl_bench.sv
// self-checking bench for the control-word decode block
module ddc_test_format_ctl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, test_enable = 0, fir_cycle_start = 0;
	logic phase_rollover = 0, ram_filled = 0, in_time_slot = 0;
	logic q_data = 1, i_data = 0, clock_data = 0, strobe_data = 1;
	logic [15:0] sample_in = 16'h1234, sample_out;
	logic [19:0] sine_in = 20'h12345, cosine_in = 20'h54321;
	logic [19:0] sine_out, cosine_out;
	logic [16:0] scale_in = 17'h00abc, scale_out;
	logic [12:0] rate_preload;
	logic sample_twos_comp, acc_enable, acc_clear, ovf_protect_en;
	logic preload_valid, update_all, output_hold, q_out, q_oe_n, i_out;
	logic serial_out_clock, output_word_strobe;
	wire ser_clk, ser_data, ser_load;
	// forced pin levels gathered into one word
	wire [3:0] pins = {serial_out_clock, output_word_strobe, i_out, q_out};
	int err_total = 0, n_compared = 0, n_upd = 0;
	int pl[4] = '{1, 2, 1701, 1702};
	always #12.5 clk = ~clk;
	// count update pulses
	always @(posedge clk)
		if (update_all === 1'b1)
			n_upd++;
	ddc_host_model u_host (.*);
	ddc_test_format_ctl u_dut (.*);
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// test word with given low fields
	task automatic w7(logic [13:0] f);
		u_host.send({3'h7, 1'b0, 22'h0, f});
	endtask : w7
	// watchdog
	initial begin
		#1ms;
		err_total++;
		give_verdict();
	end
	initial begin
		tick(16);
		rst_n = 1;
		tick(4);
		chk("q_oe_n", 1, q_oe_n);
		chk("ovf", 1, ovf_protect_en);
		fir_cycle_start = 1;
		tick(1);
		fir_cycle_start = 0;
		chk("clear", 1, acc_clear);
		for (int q = 0; q < 4; q++) begin
			u_host.send({3'h6, 1'b0, 20'h0, 2'(q), q[0], 13'h0005});
			chk("twos", q[0], sample_twos_comp);
			for (int s = 0; s < 2; s++) begin
				in_time_slot = s[0];
				tick(2);
				chk("q_oe_n", q == 0 || (q > 1 && s == 0), q_oe_n);
			end
		end
		for (int i = 0; i < 4; i++) begin
			u_host.send({3'h6, 1'b0, 23'h0, 13'(pl[i])});
			chk("preload", pl[i], rate_preload);
			chk("valid", pl[i] >= 2 && pl[i] <= 1701, preload_valid);
		end
		u_host.send({3'h6, 1'b0, 23'h0, u_host.preload(64, 1)});
		chk("preload", 13'h00ff, rate_preload);
		test_enable = 1;
		n_upd = 0;
		u_host.send({3'h7, 1'b1, 22'h0, 14'h2000});
		chk("upd", 1, n_upd);
		chk("sample", 16'h8000, sample_out);
		test_enable = 0;
		tick(2);
		chk("sample", 16'h1234, sample_out);
		test_enable = 1;
		w7(14'h0000);
		chk("upd", 1, n_upd);
		chk("sample", 16'h1234, sample_out);
		for (int c = 0; c < 4; c++) begin
			w7({1'b0, c[1:0], 11'h000});
			chk("acc_en", c != 1, acc_enable);
			fir_cycle_start = 1;
			tick(1);
			fir_cycle_start = 0;
			chk("clear", c == 0 || c == 3, acc_clear);
		end
		w7(14'h0019);
		chk("sine", 20'hfffff, sine_out);
		chk("cosine", 20'hfffff, cosine_out);
		chk("scale", 17'h10000, scale_out);
		chk("ovf", 0, ovf_protect_en);
		test_enable = 0;
		tick(2);
		chk("scale", 17'h00abc, scale_out);
		chk("ovf", 1, ovf_protect_en);
		test_enable = 1;
		w7(14'h0740);
		chk("pins", 4'ha, pins);
		w7(14'h0400);
		for (int r = 1; r >= 0; r--) begin
			phase_rollover = r[0];
			tick(2);
			chk("q_out", r, q_out);
		end
		w7(14'h0002);
		chk("hold", 1, output_hold);
		ram_filled = 1;
		tick(2);
		ram_filled = 0;
		chk("hold", 0, output_hold);
		give_verdict();
	end
endmodule : ddc_test_format_ctl_bench
